// ===== core/follower_cfg.svh
// Constants for the secondary encoder and gearing follower.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef FOLLOWER_CFG_SVH
`define FOLLOWER_CFG_SVH

// Register numbers on the register port.
`define REG_USER_LO 8'h0a
`define REG_USER_HI 8'hc7
`define REG_COUNT 8'hc8
`define REG_LATCH 8'hc9
`define REG_MODE 8'hca
`define REG_FILTER 8'hcb
`define REG_STATUS 8'hcc
`define REG_VEL 8'hcd
`define REG_SLAVE 8'hce

// Command codes.
`define CMD_SELECT_ENC 8'hc0
`define CMD_REG_GEAR 8'hdf
`define CMD_DIRECT 8'hb4

// Command parameter limits.
`define SCALE_REG_LO 16'h000a
`define SCALE_REG_HI 16'h00c7
`define DIRECT_SF_BAD 16'h8000
`define MASTER_CNT_MIN 16'h0001
`define MASTER_CNT_MAX 16'h7fff
`define INDEX_STATE_RISE 16'h0001

// Mode value that unlocks the alternate feedforward filter constants.
`define MODE_ALT_FILTER 32'h00000018

// Internal encoder resolutions and their unity scale constants.
`define CPR_4000 32'h00000fa0
`define CPR_8000 32'h00001f40
`define SF1_4000 32'h00000400
`define SF1_8000 32'h00000200
`define SF1_16000 32'h00000100

// Control loop tick.
`define LOOP_TICK_NS 120000
`define CLK_PERIOD_NS 25

`define PIN_ALL_OE 3'h7
`define FILTER_RESET 8'h00

`endif

// ===== core/follower_pkg.sv
// Types shared by the secondary encoder and gearing follower.
// Assumes nothing of its surroundings.
package follower_pkg;

    typedef enum logic [3:0] {
        STYLE_QUAD = 4'h0,
        STYLE_STEP = 4'h2,
        STYLE_GPIO = 4'h7,
        STYLE_INTERP = 4'ha
    } enc_style_t;

    typedef enum logic [1:0] {
        SRC_PIN6 = 2'h0,
        SRC_INTERNAL = 2'h2
    } index_src_t;

    typedef enum logic [1:0] {
        FOLLOW_OFF = 2'h0,
        FOLLOW_REG = 2'h1,
        FOLLOW_DIRECT = 2'h2
    } follow_t;

    typedef enum logic [0:0] {
        GEAR_IDLE = 1'h0,
        GEAR_WAIT = 1'h1
    } gear_state_t;

    typedef struct packed {
        logic [7:0] code;
        logic [15:0] p0;
        logic [15:0] p1;
        logic [15:0] p2;
    } cmd_t;

    typedef struct packed {
        logic [2:0] o;
        logic [2:0] oe;
    } pin_drive_t;

endpackage

// ===== core/serial_divider.sv
// Serial signed divider, one quotient bit per clock.
// Assumes the caller never starts it with a zero divisor.
`timescale 1ns/1ps
module serial_divider #(
    parameter int NW = 48,
    parameter int DW = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Request
    input wire logic start,
    input wire logic signed [NW-1:0] num,
    input wire logic signed [DW-1:0] den,
    // Result
    output logic busy,
    output logic done,
    output logic signed [NW-1:0] quo,
    output logic signed [DW-1:0] rem
);

    logic [NW-1:0] q_r;
    logic [DW:0] r_r;
    logic [DW-1:0] d_r;
    logic [7:0] cnt_r;
    logic negq_r;
    logic negr_r;
    logic [DW:0] trial;

    // Quotient truncates toward zero; remainder takes the dividend's sign.
    assign trial = {r_r[DW-1:0], q_r[NW-1]};
    assign quo = negq_r ? -q_r : q_r;
    assign rem = negr_r ? -r_r[DW-1:0] : r_r[DW-1:0];

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q_r <= '0;
            r_r <= '0;
            d_r <= '0;
            cnt_r <= '0;
            negq_r <= 1'b0;
            negr_r <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                q_r <= num[NW-1] ? -num : num;
                d_r <= den[DW-1] ? -den : den;
                r_r <= '0;
                cnt_r <= 8'(NW);
                negq_r <= num[NW-1] ^ den[DW-1];
                negr_r <= num[NW-1];
                busy <= 1'b1;
            end else if (busy) begin
                if (trial >= {1'b0, d_r}) begin
                    r_r <= trial - {1'b0, d_r};
                    q_r <= {q_r[NW-2:0], 1'b1};
                end else begin
                    r_r <= trial;
                    q_r <= {q_r[NW-2:0], 1'b0};
                end
                cnt_r <= cnt_r - 8'h01;
                if (cnt_r == 8'h01) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end

endmodule

// ===== core/lowpass_stage.sv
// One first-order low-pass stage with a shift-coded time constant.
// Assumes the enable is a one-cycle pulse per new sample.
`timescale 1ns/1ps
module lowpass_stage #(
    parameter int W = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Sample in
    input wire logic en,
    input wire logic [3:0] k,
    input wire logic signed [W-1:0] x,
    // Filtered value
    output logic signed [W-1:0] y
);

    logic signed [W:0] diff;

    assign diff = (W+1)'(x) - (W+1)'(y);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            y <= '0;
        end else if (en) begin
            y <= y + W'(diff >>> k);
        end
    end

endmodule

// ===== core/secondary_encoder_gearing_follower.sv
// Secondary position input and electronic gearing follower.
// Assumes a 40 MHz clock, synchronous pin inputs and a one-cycle
// command strobe that is answered by an acknowledge or a refusal.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`include "follower_cfg.svh"

// Overview of operation
// RL1: Count secondary input since clear or power-up; shown in register 200.
// RL2: On the selected index edge copy the count into register 201.
// RL3: With no secondary format in use, pin activity is ignored.
// RL4: Selecting a format never releases pins the user already drives.
// RL5: Index setting 0 latches on falling edge, 1 on rising edge.
// RL6: Multi-index encoders set index setting to CPR*3/400.
// RL7: Format 10: 201 holds target; index setting is update ticks.
// RL8: Format 10: each tick add interpolated slice of 201 change to 200.
// RL9: Format 0 quadrature, 2 step and direction, 7 frees the pins.
// RL10: Index source 0 takes pin six; 2 drives internal encoder out.
// RL11: Follow master at gear ratio; velocity double-filtered.
// RL12: Filters use loop constants unless mode 24 selects own ones.
// RL13: Scale factor equals gear ratio times resolution-dependent unity.
// RL14: Scale register may pack master change high, slave change low.
// RL15: Packed master 1 to 32767, signed slave; negative reverses.
// RL16: Register gearing code 223; register in 10 to 199.
// RL17: Host selects the input format before direct-scale follow.
// RL18: Unity constant is 1024, 512 or 256 for 4000/8000/16000 counts.
// RL19: Direct follow is code 180, signed factor magnitude up to 32767.
// RL20: Every accepted command gets a plain acknowledge, no data.
// RL21: Quadrature counts one per valid edge, direction from phase.
module secondary_encoder_gearing_follower
    import follower_pkg::*;
#(
    parameter int TICK_CYCLES = `LOOP_TICK_NS / `CLK_PERIOD_NS,
    parameter logic [31:0] INT_ENC_CPR = `CPR_4000
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Command port
    input wire logic cmd_valid,
    input wire cmd_t cmd,
    output logic cmd_ack,
    output logic cmd_nak,
    // Pins four, five and six
    input wire logic [2:0] pin_in,
    input wire pin_drive_t gp_drive,
    input wire logic [2:0] int_enc,
    output pin_drive_t pin_drive,
    output logic pins_general,
    // Control loop side
    input wire logic [3:0] vel_filt1_k,
    input wire logic [3:0] vel_filt2_k,
    output logic signed [31:0] slave_target,
    output logic signed [31:0] vel_ff,
    output logic follow_active
);

    // ===
    // Helpers
    // ===
    function automatic logic [31:0] unity_scale(input logic [31:0] cpr);
        case (cpr)
            `CPR_4000: unity_scale = `SF1_4000; // RL18
            `CPR_8000: unity_scale = `SF1_8000; // RL18
            default: unity_scale = `SF1_16000; // RL18
        endcase
    endfunction

    function automatic logic in_range(input logic [15:0] v,
                                      input logic [15:0] lo,
                                      input logic [15:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction

    localparam logic [31:0] UNITY = unity_scale(INT_ENC_CPR);

    // ===
    // Declarations
    // ===
    enc_style_t style_r;
    index_src_t idx_src_r;
    logic [15:0] idx_state_r;
    follow_t follow_r;
    logic [7:0] sf_reg_r;
    logic signed [15:0] sf_direct_r;
    logic mode_alt_r;
    logic [7:0] filt_alt_r;
    logic [31:0] user_mem [`REG_USER_LO:`REG_USER_HI];
    logic signed [31:0] count_r;
    logic signed [31:0] latch_r;
    logic [2:0] pin_p_r;
    logic [15:0] tick_cnt_r;
    logic tick_r;
    logic [15:0] interp_left_r;
    logic signed [31:0] interp_step_r;
    gear_state_t gear_state_r;
    logic signed [31:0] master_prev_r;
    logic signed [31:0] gear_frac_r;
    logic see_ok;
    logic rsd_ok;
    logic ssd_ok;
    logic counting;
    logic quad_step;
    logic quad_up;
    logic stp_step;
    logic cnt_step;
    logic cnt_up;
    logic idx_hit;
    logic wr_count;
    logic wr_latch;
    logic interp_start;
    logic interp_adv;
    logic signed [47:0] interp_num;
    logic signed [31:0] interp_den;
    logic interp_busy;
    logic interp_done;
    logic signed [47:0] interp_quo;
    logic gear_start;
    logic gear_restart;
    logic signed [31:0] gear_word;
    logic gear_packed;
    logic signed [31:0] gear_mult;
    logic signed [31:0] gear_den;
    logic signed [15:0] gear_dx;
    logic signed [47:0] gear_num;
    logic gear_done;
    logic signed [47:0] gear_quo;
    logic signed [31:0] gear_rem;
    logic [3:0] k1;
    logic [3:0] k2;
    logic signed [31:0] lp1_y;
    logic signed [31:0] lp2_y;

    // ===
    // Command decode
    // ===
    always_comb begin
        see_ok = (cmd.code == `CMD_SELECT_ENC)
            && (cmd.p0[1:0] == SRC_PIN6 || cmd.p0[1:0] == SRC_INTERNAL)
            && (cmd.p0[15:2] == '0)
            && (cmd.p2 == 16'(STYLE_QUAD) || cmd.p2 == 16'(STYLE_STEP)
                || cmd.p2 == 16'(STYLE_GPIO)
                || cmd.p2 == 16'(STYLE_INTERP)); // RL9 RL10
        rsd_ok = (cmd.code == `CMD_REG_GEAR)
            && in_range(cmd.p0, `SCALE_REG_LO, `SCALE_REG_HI); // RL16
        ssd_ok = (cmd.code == `CMD_DIRECT)
            && (cmd.p0 != `DIRECT_SF_BAD); // RL19
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            style_r <= STYLE_GPIO;
            idx_src_r <= SRC_PIN6;
            idx_state_r <= '0;
        end else if (cmd_valid && see_ok) begin
            style_r <= enc_style_t'(cmd.p2[3:0]); // RL9
            idx_src_r <= index_src_t'(cmd.p0[1:0]); // RL10
            idx_state_r <= cmd.p1; // RL5 RL7
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            follow_r <= FOLLOW_OFF;
            sf_reg_r <= `REG_USER_LO;
            sf_direct_r <= '0;
        end else if (cmd_valid && rsd_ok) begin
            follow_r <= FOLLOW_REG; // RL16
            sf_reg_r <= cmd.p0[7:0];
        end else if (cmd_valid && ssd_ok) begin
            follow_r <= FOLLOW_DIRECT; // RL19
            sf_direct_r <= cmd.p0;
        end
    end

    // Answers carry no data, only accept or refuse.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cmd_ack <= 1'b0;
            cmd_nak <= 1'b0;
        end else begin
            cmd_ack <= cmd_valid && (see_ok || rsd_ok || ssd_ok); // RL20
            cmd_nak <= cmd_valid && !(see_ok || rsd_ok || ssd_ok);
        end
    end

    // ===
    // Pins
    // ===
    // User drive passes through untouched unless the internal encoder
    // is routed out, so a format change never floats a driven pin.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_drive <= '0;
            pins_general <= 1'b1;
        end else begin
            if (idx_src_r == SRC_INTERNAL) begin
                pin_drive <= '{o: int_enc, oe: `PIN_ALL_OE}; // RL10
            end else begin
                pin_drive <= gp_drive; // RL4
            end
            pins_general <= (style_r == STYLE_GPIO); // RL9
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_p_r <= '0;
        end else begin
            pin_p_r <= pin_in;
        end
    end

    // ===
    // Edge decode and counter
    // ===
    always_comb begin
        counting = (style_r == STYLE_QUAD) || (style_r == STYLE_STEP); // RL3
        quad_step = (pin_in[0] ^ pin_p_r[0]) ^ (pin_in[1] ^ pin_p_r[1]);
        quad_up = pin_in[0] ^ pin_p_r[1]; // RL21
        stp_step = pin_in[0] && !pin_p_r[0];
        cnt_step = counting
            && ((style_r == STYLE_QUAD) ? quad_step : stp_step);
        cnt_up = (style_r == STYLE_QUAD) ? quad_up : pin_in[1];
        // Any setting other than one, multi-index ones included,
        // latches on the falling edge.
        idx_hit = counting && ((idx_state_r == `INDEX_STATE_RISE)
            ? (pin_in[2] && !pin_p_r[2])
            : (!pin_in[2] && pin_p_r[2])); // RL5 RL6
        wr_count = reg_wr && (reg_addr == `REG_COUNT);
        wr_latch = reg_wr && (reg_addr == `REG_LATCH);
        interp_start = wr_latch && (style_r == STYLE_INTERP); // RL7
        interp_adv = (style_r == STYLE_INTERP) && tick_r
            && (interp_left_r != '0) && !interp_busy;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_r <= '0;
        end else if (wr_count) begin
            count_r <= reg_wdata; // RL1
        end else if (interp_adv) begin
            if (interp_left_r == 16'h0001) begin
                count_r <= latch_r; // RL8
            end else begin
                count_r <= count_r + interp_step_r; // RL8
            end
        end else if (cnt_step) begin
            count_r <= cnt_up ? count_r + 32'sh1 : count_r - 32'sh1; // RL1
        end
    end

    // A latch event in the same cycle as a software write wins.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            latch_r <= '0;
        end else if (idx_hit) begin
            latch_r <= count_r; // RL2
        end else if (wr_latch) begin
            latch_r <= reg_wdata; // RL7
        end
    end

    // ===
    // Control loop tick and target interpolation
    // ===
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tick_cnt_r <= '0;
            tick_r <= 1'b0;
        end else begin
            tick_r <= (tick_cnt_r == 16'(TICK_CYCLES - 1));
            if (tick_cnt_r == 16'(TICK_CYCLES - 1)) begin
                tick_cnt_r <= '0;
            end else begin
                tick_cnt_r <= tick_cnt_r + 16'h0001;
            end
        end
    end

    assign interp_num = 48'(signed'(reg_wdata)) - 48'(latch_r); // RL8
    assign interp_den = (idx_state_r == '0) ? 32'sh1
        : 32'(idx_state_r); // RL7

    serial_divider #(.NW(48), .DW(32)) u_interp_div (
        .clk(clk),
        .resetn(resetn),
        .start(interp_start),
        .num(interp_num),
        .den(interp_den),
        .busy(interp_busy),
        .done(interp_done),
        .quo(interp_quo),
        .rem()
    );

    // The final tick lands exactly on the target to absorb rounding.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            interp_left_r <= '0;
            interp_step_r <= '0;
        end else begin
            if (interp_done) begin
                interp_step_r <= 32'(interp_quo); // RL8
            end
            if (interp_start) begin
                interp_left_r <= 16'(interp_den); // RL7
            end else if (interp_adv) begin
                interp_left_r <= interp_left_r - 16'h0001;
            end
        end
    end

    // ===
    // Gearing
    // ===
    always_comb begin
        gear_word = user_mem[sf_reg_r];
        gear_packed = in_range(gear_word[31:16], `MASTER_CNT_MIN,
            `MASTER_CNT_MAX); // RL14 RL15
        if (follow_r == FOLLOW_DIRECT) begin
            gear_mult = 32'(sf_direct_r); // RL19
            gear_den = UNITY; // RL13
        end else if (gear_packed) begin
            gear_mult = 32'(signed'(gear_word[15:0])); // RL15
            gear_den = 32'(gear_word[31:16]); // RL14
        end else begin
            gear_mult = gear_word; // RL13
            gear_den = UNITY;
        end
        gear_dx = 16'(count_r - master_prev_r);
        gear_num = 48'(gear_dx) * 48'(gear_mult)
            + 48'(gear_frac_r); // RL11
        gear_restart = cmd_valid && (rsd_ok || ssd_ok);
        gear_start = tick_r && (follow_r != FOLLOW_OFF)
            && (gear_state_r == GEAR_IDLE) && !gear_restart;
    end

    serial_divider #(.NW(48), .DW(32)) u_gear_div (
        .clk(clk),
        .resetn(resetn),
        .start(gear_start),
        .num(gear_num),
        .den(gear_den),
        .busy(),
        .done(gear_done),
        .quo(gear_quo),
        .rem(gear_rem)
    );

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            gear_state_r <= GEAR_IDLE;
            master_prev_r <= '0;
            gear_frac_r <= '0;
        end else if (gear_restart) begin
            gear_state_r <= GEAR_IDLE;
            master_prev_r <= count_r;
            gear_frac_r <= '0;
        end else begin
            case (gear_state_r)
                GEAR_IDLE: begin
                    if (gear_start) begin
                        master_prev_r <= master_prev_r + 32'(gear_dx);
                        gear_state_r <= GEAR_WAIT;
                    end
                end
                GEAR_WAIT: begin
                    if (gear_done) begin
                        gear_frac_r <= gear_rem; // RL11
                        gear_state_r <= GEAR_IDLE;
                    end
                end
                default: gear_state_r <= GEAR_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            slave_target <= '0;
            follow_active <= 1'b0;
        end else begin
            if (gear_done) begin
                slave_target <= slave_target + 32'(gear_quo); // RL11
            end
            follow_active <= (follow_r != FOLLOW_OFF);
        end
    end

    // ===
    // Velocity feedforward estimate
    // ===
    assign k1 = mode_alt_r ? filt_alt_r[3:0] : vel_filt1_k; // RL12
    assign k2 = mode_alt_r ? filt_alt_r[7:4] : vel_filt2_k; // RL12

    lowpass_stage #(.W(32)) u_lp1 (
        .clk(clk),
        .resetn(resetn),
        .en(gear_done),
        .k(k1),
        .x(32'(gear_quo)),
        .y(lp1_y)
    );

    lowpass_stage #(.W(32)) u_lp2 (
        .clk(clk),
        .resetn(resetn),
        .en(gear_done),
        .k(k2),
        .x(lp1_y),
        .y(lp2_y)
    );

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            vel_ff <= '0;
        end else begin
            vel_ff <= lp2_y; // RL11
        end
    end

    // ===
    // Register port
    // ===
    always_ff @(posedge clk) begin
        if (reg_wr && reg_addr >= `REG_USER_LO
                && reg_addr <= `REG_USER_HI) begin
            user_mem[reg_addr] <= reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode_alt_r <= 1'b0;
            filt_alt_r <= `FILTER_RESET;
        end else begin
            if (reg_wr && reg_addr == `REG_MODE) begin
                mode_alt_r <= (reg_wdata == `MODE_ALT_FILTER); // RL12
            end
            if (reg_wr && reg_addr == `REG_FILTER) begin
                filt_alt_r <= reg_wdata[7:0];
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            if (reg_addr >= `REG_USER_LO && reg_addr <= `REG_USER_HI) begin
                reg_rdata <= user_mem[reg_addr];
            end else begin
                case (reg_addr)
                    `REG_COUNT: reg_rdata <= count_r; // RL1
                    `REG_LATCH: reg_rdata <= latch_r; // RL2
                    `REG_MODE: reg_rdata <= {31'h0, mode_alt_r};
                    `REG_FILTER: reg_rdata <= {24'h0, filt_alt_r};
                    `REG_STATUS: reg_rdata <= {interp_left_r, 7'h0,
                        gear_state_r, follow_r, idx_src_r, style_r};
                    `REG_VEL: reg_rdata <= lp2_y;
                    `REG_SLAVE: reg_rdata <= slave_target;
                    default: reg_rdata <= '0;
                endcase
            end
        end else begin
            reg_rdata <= '0;
        end
    end

endmodule

// ===== verification/follower_checker.sv
// Concurrent checks on the follower's register and command ports.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module follower_checker
    import follower_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Requests
    input wire logic reg_rd,
    input wire logic cmd_valid,
    input wire cmd_t cmd,
    input wire pin_drive_t gp_drive,
    // Answers
    input wire logic [31:0] reg_rdata,
    input wire logic cmd_ack,
    input wire logic cmd_nak,
    input wire pin_drive_t pin_drive
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_one_answer:
        assert property (cmd_valid |=> cmd_ack != cmd_nak)
        else $error("command not answered by one pulse");
    a_no_stray:
        assert property (!cmd_valid |=> !cmd_ack && !cmd_nak)
        else $error("answer without a command");
    a_read_idle:
        assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data outside its cycle");
    a_unknown_refused:
        assert property (cmd_valid && !(cmd.code inside {8'hc0, 8'hdf,
            8'hb4}) |=> cmd_nak)
        else $error("unknown code accepted");
    a_gear_range:
        assert property (cmd_valid && cmd.code == 8'hdf |=>
            cmd_ack == ($past(cmd.p0) inside {[16'ha:16'hc7]}))
        else $error("gearing register range wrong");
    a_direct_limit:
        assert property (cmd_valid && cmd.code == 8'hb4 |=>
            cmd_nak == ($past(cmd.p0) == 16'h8000))
        else $error("direct factor limit wrong");
    a_style_codes:
        assert property (cmd_valid && cmd.code == 8'hc0 && cmd.p0 == 16'h0
            |=> cmd_ack == ($past(cmd.p2) inside {16'h0, 16'h2, 16'h7,
            16'ha}))
        else $error("format code handling wrong");
    a_drive_kept:
        assert property (cmd_valid && cmd.code == 8'hc0 && cmd.p0 == 16'h0
            && cmd.p2 == 16'h2 |-> ##3 pin_drive == $past(gp_drive))
        else $error("pin drive lost on format select");
endmodule
bind secondary_encoder_gearing_follower follower_checker chk_i (.clk,
    .resetn, .reg_rd, .cmd_valid, .cmd, .gp_drive, .reg_rdata, .cmd_ack,
    .cmd_nak, .pin_drive);

// ===== verification/encoder_source.sv
// Model of the external encoder or step and direction source.
// Assumes the bench pulses run once per step, slowly or promptly.
`timescale 1ns/1ps
module encoder_source (
    // Control
    input wire logic clk,
    input wire logic run,
    input wire logic up,
    input wire logic step_dir,
    input wire logic idx,
    // Pins four, five and six
    output logic [2:0] pins
);
    logic [1:0] ph_r = 2'h0;
    always @(posedge clk) begin
        if (run)
            ph_r <= up ? ph_r + 2'h1 : ph_r - 2'h1;
    end
    // Going up, A changes a step ahead of B.
    assign pins = step_dir ? {idx, up, ph_r[0]} : {idx, ph_r[1], ^ph_r};
endmodule

// ===== verification/secondary_encoder_gearing_follower_tb.sv
// Self-checking bench for the secondary encoder and gearing follower.
// Assumes the design, checker and source model are compiled first.
`timescale 1ns/1ps
module secondary_encoder_gearing_follower_tb;
    import follower_pkg::*;
    logic clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, cmd_valid = 0;
    logic run = 0, up = 1, sd = 0, idx = 0, cmd_ack, cmd_nak, fa;
    logic [7:0] reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, slave_target;
    logic [2:0] pin_in;
    cmd_t cmd = '0;
    pin_drive_t gp_drive = 6'h24, pin_drive;
    int error_cnt = 0, samples_checked = 0;
    always #12.5 clk = ~clk;
    secondary_encoder_gearing_follower #(.TICK_CYCLES(64)) uut (.clk,
        .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .cmd_valid, .cmd, .cmd_ack, .cmd_nak, .pin_in, .gp_drive,
        .int_enc(3'h0), .pin_drive, .pins_general(), .vel_filt1_k(4'h1),
        .vel_filt2_k(4'h2), .slave_target, .vel_ff(), .follow_active(fa));
    encoder_source src (.clk, .run, .up, .step_dir(sd), .idx, .pins(pin_in));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk) reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk) reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
        @(posedge clk);
    endtask
    task cm(input cmd_t v, input logic ok);
        cmd <= v;
        cmd_valid <= 1'b1;
        @(posedge clk) cmd_valid <= 1'b0;
        #1 chk(32'({cmd_ack, cmd_nak}), 32'({ok, !ok}));
        @(posedge clk);
    endtask
    task mv(input int n, input logic u);
        up <= u;
        repeat (n) begin
            run <= 1'b1;
            @(posedge clk) run <= 1'b0;
            repeat (2) @(posedge clk);
        end
        repeat (3) @(posedge clk);
    endtask
    task t_regs;
        wr(8'hca, 32'h18);
        rd(8'hca, 32'h1);
        wr(8'hc8, 32'h1234);
        rd(8'hc8, 32'h1234);
        wr(8'h0b, 32'h00010002);
        rd(8'h0b, 32'h00010002);
        rd(8'h05, 32'h0);
        mv(8, 1'b1);
        rd(8'hc8, 32'h1234);
    endtask
    task t_cmds;
        cm({8'h11, 48'h0}, 1'b0);
        cm({8'hdf, 16'h9, 32'h0}, 1'b0);
        cm({8'hdf, 16'hc8, 32'h0}, 1'b0);
        cm({8'hb4, 16'h8000, 32'h0}, 1'b0);
        cm({8'hc0, 16'h1, 32'h0}, 1'b0);
        cm({8'hc0, 32'h0, 16'h3}, 1'b0);
    endtask
    task t_quad;
        cm({8'hc0, 16'h0, 16'h1, 16'h0}, 1'b1);
        wr(8'hc8, 32'h0);
        mv(8, 1'b1);
        rd(8'hc8, 32'h8);
        mv(3, 1'b0);
        rd(8'hc8, 32'h5);
        idx <= 1'b1;
        mv(0, 1'b1);
        rd(8'hc9, 32'h5);
        idx <= 1'b0;
        mv(1, 1'b1);
        rd(8'hc9, 32'h5);
        cm({8'hc0, 16'h0, 16'd60, 16'h0}, 1'b1);
        idx <= 1'b1;
        mv(1, 1'b1);
        idx <= 1'b0;
        mv(0, 1'b1);
        rd(8'hc9, 32'h7);
    endtask
    task t_step;
        sd <= 1'b1;
        cm({8'hc0, 32'h0, 16'h2}, 1'b1);
        wr(8'hc8, 32'h0);
        mv(12, 1'b1);
        rd(8'hc8, 32'h6);
    endtask
    task t_interp;
        cm({8'hc0, 16'h0, 16'h2, 16'ha}, 1'b1);
        wr(8'hc9, 32'd100);
        repeat (300) @(posedge clk);
        rd(8'hc8, 32'd100);
        mv(4, 1'b1);
        rd(8'hc8, 32'd100);
    endtask
    task t_gear;
        sd <= 1'b0;
        cm({8'hc0, 48'h0}, 1'b1);
        wr(8'hc8, 32'h0);
        cm({8'hdf, 16'hb, 32'h0}, 1'b1);
        mv(10, 1'b1);
        repeat (300) @(posedge clk);
        chk(slave_target, 32'd20);
        chk(32'(fa), 32'h1);
        cm({8'hb4, 16'hfc00, 32'h0}, 1'b1);
        mv(5, 1'b1);
        repeat (300) @(posedge clk);
        chk(slave_target, 32'd15);
    endtask
    task test_done;
        if (error_cnt == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        t_regs;
        t_cmds;
        t_quad;
        t_step;
        t_interp;
        t_gear;
        test_done;
    end
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        test_done;
    end
endmodule
